// File: include/v110_rx_pkg.sv
// ==========================================================
// Frame geometry
package v110_rx_pkg;

	// Octet numbers within the ten-octet frame
	localparam logic [3:0] OCT_SYNC = 4'h1;
	localparam logic [3:0] OCT_ALIGN = 4'h2;
	localparam logic [3:0] OCT_EBITS = 4'h6;
	localparam logic [3:0] OCT_LAST = 4'hA;
	// Bit numbers within an octet, zero means bit 1
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_AFTER_ALIGN = 3'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ==========================================================
	// Synchronizer figures
	localparam logic [3:0] ZERO_RUN = 4'h8;
	localparam logic [1:0] LOSS_FRAMES = 2'h3;

	// ==========================================================
	// Rate pattern codes
	localparam logic [1:0] RATE_600 = 2'h0;
	localparam logic [1:0] RATE_1200 = 2'h1;
	localparam logic [1:0] RATE_2400 = 2'h2;
	localparam logic [1:0] RATE_FULL = 2'h3;

	// ==========================================================
	// Status vector layout (bit 8 of octets 2..10, then E1..E6)
	localparam int STAT_W = 15;
	localparam logic [3:0] STAT_E1 = 4'h9;
	localparam int E7_IDX = 4;
	localparam int X2_IDX = 6;
	localparam int SA_IDX = 7;
	localparam int SB_IDX = 8;

	// ==========================================================
	// Data word layout
	localparam logic [2:0] GROUP_LAST_BIT = 3'h5;
	localparam logic [1:0] WORD_LAST_GROUP = 2'h3;
	localparam logic [31:0] WORD_PRESET = 32'hC0C0C0C0;

	// Synchronizer states
	typedef enum logic [1:0]
	{
		SYNC_HUNT = 2'b01,
		SYNC_LOCKED = 2'b10
	} sync_state_t;

	// Per-channel configuration
	typedef struct packed
	{
		logic [1:0] ratePatternSelect;
		logic channelFlip;
		logic intelOrder;
		logic alterationIrqMask;
		logic rxIrqMask;
	} channel_cfg_t;

	// Bit-change report
	typedef struct packed
	{
		logic [6:0] eBits;
		logic statusB;
		logic statusA;
		logic xBit;
	} change_report_t;

endpackage

// File: src/v110_receive_deframer.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Receive deframer for one rate-adapted channel
module v110_receive_deframer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Channel configuration
	input wire v110_rx_pkg::channel_cfg_t cfg,
	// Time-slot bit stream, one bit per strobe
	input wire logic lineValid,
	input wire logic lineBit,
	// Host side conditions
	input wire logic bufferReady,
	input wire logic fastAbort,
	input wire logic holdMarker,
	// Data section writes
	output logic wordValid,
	output logic [31:0] wordData,
	// Events and status
	output logic bitChangeEvent,
	output var v110_rx_pkg::change_report_t changeReport,
	output logic rxErrorEvent,
	output logic overrunEvent,
	output logic inSync
);
	import v110_rx_pkg::*;

	// ==========================================================
	// Position decoding helpers

	// Last copy of a repeated bit, by rate
	function automatic logic lastCopy(input logic [1:0] rate, input logic [5:0] cnt);
		case (rate)
			RATE_600: lastCopy = &cnt[2:0];
			RATE_1200: lastCopy = &cnt[1:0];
			RATE_2400: lastCopy = cnt[0];
			default: lastCopy = 1'b1;
		endcase
	endfunction

	// Bit 8 of octets 2..10, or E1..E6 in octet 6
	function automatic logic isStatPos(input logic [3:0] oct, input logic [2:0] bn);
		isStatPos = (bn == BIT_LAST && oct != OCT_SYNC)
			|| (oct == OCT_EBITS && bn != BIT_FIRST);
	endfunction

	// Index into the status vector
	function automatic logic [3:0] statIndex(input logic [3:0] oct, input logic [2:0] bn);
		if (bn == BIT_LAST)
			statIndex = oct - OCT_ALIGN;
		else
			statIndex = STAT_E1 + {1'b0, bn} - 4'h1;
	endfunction

	// ==========================================================
	// Declarations
	sync_state_t state_r; // Synchronizer state
	sync_state_t state_nxt;
	logic inBit; // Bit after optional inversion
	logic [3:0] zeroRun_r; // Consecutive zeros while hunting
	logic [3:0] zeroRun_nxt;
	logic [3:0] octet_r; // Current octet, 1..10
	logic [2:0] bitNo_r; // Current bit, 0 means bit 1
	logic [1:0] badCnt_r; // Consecutive frames with pattern error
	logic frameErr_r; // Pattern error seen in this frame
	logic [5:0] dataCnt_r; // Data position within frame
	logic hunt;
	logic locked;
	logic bitIn; // A bit is being processed while locked
	logic startSeen; // Start sequence completes now
	logic patErr; // This bit breaks the pattern
	logic frameEnd; // Last bit of the frame
	logic frameBad;
	logic lossSync;
	logic isData;
	logic userStrobe; // Bit handed to the packer
	logic statHit;
	logic [3:0] statIdx;
	logic [STAT_W-1:0] statCur_r; // Values collected this frame
	logic [STAT_W-1:0] statPrev_r; // Values of the previous frame
	logic [STAT_W-1:0] statCurNxt;
	logic statKnown_r; // Previous frame is complete
	logic changePend_r; // Change seen earlier in this frame
	logic changeNow;
	logic changeFound;
	logic wordDrop;

	// ==========================================================
	// Input conditioning
	// Inversion sits ahead of everything, so framing bits flip too
	assign inBit = lineBit ^ cfg.channelFlip;

	// ==========================================================
	// Decoding
	assign hunt = state_r == SYNC_HUNT;
	assign locked = state_r == SYNC_LOCKED;
	assign bitIn = locked && lineValid;
	assign startSeen = hunt && lineValid && inBit && zeroRun_r == ZERO_RUN;
	assign patErr = (octet_r == OCT_SYNC && inBit)
		|| (octet_r != OCT_SYNC && bitNo_r == BIT_FIRST && !inBit);
	assign frameEnd = bitIn && octet_r == OCT_LAST && bitNo_r == BIT_LAST;
	assign frameBad = frameErr_r || patErr;
	assign lossSync = frameEnd && frameBad && badCnt_r == LOSS_FRAMES - 2'h1;
	// Data sits in bits 2..7 of every octet except 1 and 6
	assign isData = bitIn && octet_r != OCT_SYNC && octet_r != OCT_EBITS
		&& bitNo_r != BIT_FIRST && bitNo_r != BIT_LAST;
	assign userStrobe = isData && lastCopy(cfg.ratePatternSelect, dataCnt_r);
	assign statHit = bitIn && isStatPos(octet_r, bitNo_r);
	assign statIdx = statIndex(octet_r, bitNo_r);
	assign inSync = locked;

	// Zero counter saturates so a long idle run still qualifies
	assign zeroRun_nxt = inBit ? 4'h0
		: (zeroRun_r == ZERO_RUN ? zeroRun_r : zeroRun_r + 4'h1);

	// ==========================================================
	// Synchronizer
	// Only two states; any stray code falls back to hunting
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SYNC_HUNT:
				if (startSeen)
					state_nxt = SYNC_LOCKED;
			SYNC_LOCKED:
				if (lossSync)
					state_nxt = SYNC_HUNT;
			default:
				state_nxt = SYNC_HUNT;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_r <= SYNC_HUNT;
		else
			state_r <= state_nxt;
	end

	// Zero run, restarted on loss so search begins afresh
	always_ff @(posedge sys_clk)
	begin
		if (rst || lossSync)
			zeroRun_r <= 4'h0;
		else if (hunt && lineValid)
			zeroRun_r <= zeroRun_nxt;
	end

	// ==========================================================
	// Frame position
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			octet_r <= OCT_SYNC;
			bitNo_r <= BIT_FIRST;
		end
		else if (startSeen)
		begin
			// The one bit just taken was bit 1 of octet 2
			octet_r <= OCT_ALIGN;
			bitNo_r <= BIT_AFTER_ALIGN;
		end
		else if (bitIn)
		begin
			bitNo_r <= bitNo_r + 3'h1;
			if (bitNo_r == BIT_LAST)
				octet_r <= (octet_r == OCT_LAST) ? OCT_SYNC : octet_r + 4'h1;
		end
	end

	// Pattern error latch and bad-frame count
	always_ff @(posedge sys_clk)
	begin
		if (rst || startSeen || frameEnd)
			frameErr_r <= 1'b0;
		else if (bitIn && patErr)
			frameErr_r <= 1'b1;
	end

	// A good frame clears the run of bad ones
	always_ff @(posedge sys_clk)
	begin
		if (rst || startSeen)
			badCnt_r <= 2'h0;
		else if (frameEnd)
			badCnt_r <= frameBad ? badCnt_r + 2'h1 : 2'h0;
	end

	// Data position count, cleared in the sync octet
	always_ff @(posedge sys_clk)
	begin
		if (rst || startSeen || (bitIn && octet_r == OCT_SYNC))
			dataCnt_r <= 6'h00;
		else if (isData)
			dataCnt_r <= dataCnt_r + 6'h01;
	end

	// ==========================================================
	// Status bit monitor
	always_comb
	begin
		statCurNxt = statCur_r;
		if (statHit)
			statCurNxt[statIdx] = inBit;
	end

	// Compared on arrival, so an S8 or S9 change is caught in-frame
	assign changeNow = statHit && statKnown_r && inBit != statPrev_r[statIdx];
	assign changeFound = changePend_r || changeNow;

	// Collect frame values and remember the previous frame
	always_ff @(posedge sys_clk)
	begin
		if (rst || startSeen)
		begin
			statCur_r <= '0;
			statPrev_r <= '0;
			statKnown_r <= 1'b0;
			changePend_r <= 1'b0;
		end
		else
		begin
			statCur_r <= statCurNxt;
			if (frameEnd)
			begin
				statPrev_r <= statCurNxt;
				statKnown_r <= 1'b1;
				changePend_r <= 1'b0;
			end
			else if (changeNow)
				changePend_r <= 1'b1;
		end
	end

	// ==========================================================
	// Events
	// Report at frame end only, hence one per frame at most
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			bitChangeEvent <= 1'b0;
			changeReport <= '0;
			rxErrorEvent <= 1'b0;
			overrunEvent <= 1'b0;
		end
		else
		begin
			bitChangeEvent <= frameEnd && changeFound && bufferReady
				&& !cfg.alterationIrqMask;
			if (frameEnd && changeFound)
			begin
				changeReport.eBits <= {statCurNxt[E7_IDX], statCurNxt[14:9]};
				changeReport.statusB <= statCurNxt[SB_IDX];
				changeReport.statusA <= statCurNxt[SA_IDX];
				changeReport.xBit <= statCurNxt[X2_IDX];
			end
			rxErrorEvent <= !cfg.rxIrqMask && ((lossSync && bufferReady)
				|| fastAbort || holdMarker || wordDrop);
			// Reports that cannot be stored are flagged instead
			overrunEvent <= !cfg.rxIrqMask && !bufferReady
				&& (lossSync || (frameEnd && changeFound));
		end
	end

	// ==========================================================
	// Word assembly; restarted on each new lock
	v110_word_packer u_packer (
		.sys_clk(sys_clk),
		.rst(rst),
		.bitStrobe(userStrobe),
		.bitVal(inBit),
		.intelOrder(cfg.intelOrder),
		.restart(startSeen),
		.bufferReady(bufferReady),
		.wordValid(wordValid),
		.wordData(wordData),
		.wordDrop(wordDrop)
	);

	// ==========================================================
	// Checks
	chk_start_lock: assert property (@(posedge sys_clk) disable iff (rst)
		hunt && lineValid && inBit && zeroRun_r == 4'h8 |=> locked)
		else $error("start sequence did not lock");

	chk_three_bad: assert property (@(posedge sys_clk) disable iff (rst)
		frameEnd && frameBad && badCnt_r == 2'h2 |=> hunt && zeroRun_r == 4'h0)
		else $error("third bad frame kept lock");

	chk_two_states: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == SYNC_HUNT || state_r == SYNC_LOCKED)
		else $error("synchronizer left its two states");

	chk_hunt_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		hunt |-> !userStrobe && !statHit && !frameEnd)
		else $error("extraction while hunting");

	chk_align_pos: assert property (@(posedge sys_clk) disable iff (rst)
		startSeen |=> octet_r == 4'h2 && bitNo_r == 3'h1 && dataCnt_r == 6'h00)
		else $error("frame not aligned to start bit");

	chk_event_frame: assert property (@(posedge sys_clk) disable iff (rst)
		bitChangeEvent |-> $past(frameEnd) && !$past(cfg.alterationIrqMask))
		else $error("bit-change event off frame end");

	chk_last_copy: assert property (@(posedge sys_clk) disable iff (rst)
		userStrobe && cfg.ratePatternSelect == 2'h0 |-> dataCnt_r[2:0] == 3'h7)
		else $error("600 rate sampled early copy");

	chk_flip_sense: assert property (@(posedge sys_clk) disable iff (rst)
		startSeen |-> lineBit != cfg.channelFlip)
		else $error("start bit taken at wrong polarity");

	chk_loss_report: assert property (@(posedge sys_clk) disable iff (rst)
		lossSync && !cfg.rxIrqMask |=> rxErrorEvent || overrunEvent)
		else $error("loss of sync not reported");

endmodule // v110_receive_deframer

`default_nettype wire

// File: src/v110_word_packer.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Six-bit groups into 32-bit data words
module v110_word_packer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Extracted user bits
	input wire logic bitStrobe,
	input wire logic bitVal,
	input wire logic intelOrder,
	input wire logic restart,
	// Data section side
	input wire logic bufferReady,
	output logic wordValid,
	output logic [31:0] wordData,
	output logic wordDrop
);
	import v110_rx_pkg::*;

	logic [2:0] bitIdx_r; // Bit within group
	logic [1:0] grp_r; // Group within word
	logic [31:0] word_r; // Word under assembly
	logic [31:0] wordFull; // Word with current bit placed
	logic [4:0] slot; // Target bit position
	logic groupDone;
	logic wordDone;

	// Intel fills from the bottom, Motorola from the top
	assign slot = intelOrder ? {grp_r, bitIdx_r} : {~grp_r, bitIdx_r};
	assign groupDone = bitStrobe && bitIdx_r == GROUP_LAST_BIT;
	assign wordDone = groupDone && grp_r == WORD_LAST_GROUP;

	// Place the bit; marker ones come from the preset
	always_comb
	begin
		wordFull = word_r;
		wordFull[slot] = bitVal;
	end

	// Assembly; a restart drops any partial word
	always_ff @(posedge sys_clk)
	begin
		if (rst || restart)
		begin
			bitIdx_r <= 3'h0;
			grp_r <= 2'h0;
			word_r <= WORD_PRESET;
		end
		else if (bitStrobe)
		begin
			word_r <= wordDone ? WORD_PRESET : wordFull;
			bitIdx_r <= groupDone ? 3'h0 : bitIdx_r + 3'h1;
			grp_r <= groupDone ? grp_r + 2'h1 : grp_r;
		end
	end

	// Output stage; no room means the word is lost
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wordValid <= 1'b0;
			wordData <= 32'h00000000;
			wordDrop <= 1'b0;
		end
		else
		begin
			wordValid <= wordDone && bufferReady;
			wordDrop <= wordDone && !bufferReady;
			if (wordDone)
				wordData <= wordFull;
		end
	end

	chk_word_markers: assert property (@(posedge sys_clk) disable iff (rst)
		wordValid |-> wordData[31:30] == 2'b11 && wordData[23:22] == 2'b11
			&& wordData[15:14] == 2'b11 && wordData[7:6] == 2'b11)
		else $error("data word marker ones missing");

	chk_word_fill: assert property (@(posedge sys_clk) disable iff (rst)
		wordValid |-> $past(bitStrobe) && $past(grp_r) == 2'h3 && $past(bitIdx_r) == 3'h5)
		else $error("data word written before 24 bits");

endmodule // v110_word_packer

`default_nettype wire

// File: verification/tb_v110_receive_deframer.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Self-checking bench for the receive deframer
module tb_v110_receive_deframer;
	import v110_rx_pkg::*;

	logic sys_clk = 1'b0; // 125 MHz
	logic rst; // Held from time zero by the main sequence
	channel_cfg_t cfg; // Set per scenario
	logic bufferReady; // Raised by the main sequence, dropped by the change scenario
	logic fastAbort;
	logic holdMarker;
	wire logic lineValid;
	wire logic lineBit;
	wire logic wordValid;
	wire logic [31:0] wordData;
	wire logic bitChangeEvent;
	change_report_t changeReport;
	wire logic rxErrorEvent;
	wire logic overrunEvent;
	wire logic inSync;
	int mismatches = 0;
	int checks_done = 0;
	int nChange = 0; // Event tallies, cleared per scenario
	int nError = 0;
	int nOverrun = 0;
	logic [31:0] words[$]; // Captured data words

	always #4 sys_clk = ~sys_clk;

	v110_line_model v110_line_model_inst (.sys_clk(sys_clk), .lineValid(lineValid),
		.lineBit(lineBit));
	v110_receive_deframer v110_receive_deframer_inst (.sys_clk(sys_clk), .rst(rst),
		.cfg(cfg), .lineValid(lineValid), .lineBit(lineBit), .bufferReady(bufferReady),
		.fastAbort(fastAbort), .holdMarker(holdMarker), .wordValid(wordValid),
		.wordData(wordData), .bitChangeEvent(bitChangeEvent), .changeReport(changeReport),
		.rxErrorEvent(rxErrorEvent), .overrunEvent(overrunEvent), .inSync(inSync));

	// ==========================================================
	// Monitor: pulses stand one cycle, so tally on every edge
	always @(posedge sys_clk)
	begin
		if (wordValid === 1'b1)
			words.push_back(wordData);
		nChange += (bitChangeEvent === 1'b1);
		nError += (rxErrorEvent === 1'b1);
		nOverrun += (overrunEvent === 1'b1);
	end

	// ==========================================================
	// Helpers
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Fresh start per scenario, three cycles of reset
	task automatic restart(input channel_cfg_t c);
		v110_line_model_inst.go_idle(2);
		rst = 1'b1;
		// Caller's settings stand for a channel already put in this mode
		cfg = c;
		repeat (3) step();
		rst = 1'b0;
		nChange = 0;
		nError = 0;
		nOverrun = 0;
		words.delete();
	endtask

	// Clean-data frame at the full rate
	task automatic frame(input logic bad, input logic [8:0] st, input logic [5:0] e);
		v110_line_model_inst.send_frame(48'h0, st, e, bad, 1'b0);
	endtask

	// User bit k of the reference stream
	function automatic logic uval(input int k, input logic [1:0] r);
		return ((k % 3) == 0) ^ (((k / 4) % 2) == 1) ^ r[0];
	endfunction

	// Expected word w: two ones above each six-bit group
	function automatic logic [31:0] mk_word(input int w, input logic [1:0] r, input logic intel);
		logic [31:0] v;
		logic [5:0] g;
		v = '0;
		for (int i = 0; i < 4; i++)
		begin
			for (int j = 0; j < 6; j++)
				g[j] = uval(24 * w + 6 * i + j, r);
			if (intel)
				v[8 * i +: 8] = {2'b11, g};
			else
				v[8 * (3 - i) +: 8] = {2'b11, g};
		end
		return v;
	endfunction

	// ==========================================================
	// Scenarios
	// Earlier copies carry the inverse, so only the last copy may be kept
	task automatic test_rate(input logic [1:0] r, input int s);
		channel_cfg_t c;
		logic [47:0] d;
		c = '0;
		c.ratePatternSelect = r;
		c.intelOrder = r[0];
		c.channelFlip = (r == RATE_FULL);
		restart(c);
		chk_word({31'h0, inSync}, 32'h0);
		for (int f = 0; f < 4; f++)
		begin
			for (int p = 0; p < 48; p++)
				d[p] = uval(f * (48 / s) + p / s, r) ^ ((p % s) != (s - 1));
			v110_line_model_inst.send_frame(d, 9'h1FF, 6'h3F, 1'b0, c.channelFlip);
		end
		v110_line_model_inst.go_idle(4);
		chk_word({31'h0, inSync}, 32'h1);
		chk_count(words.size(), 8 / s);
		for (int w = 0; w < words.size(); w++)
			chk_word(words[w], mk_word(w, r, c.intelOrder));
		$display("test rate %0d done", r);
	endtask

	// Two bad frames tolerated, third loses lock, hunting extracts nothing
	task automatic test_sync();
		channel_cfg_t c;
		int n;
		c = '0;
		c.ratePatternSelect = RATE_FULL;
		restart(c);
		frame(0, 9'h0, 6'h0);
		frame(1, 9'h0, 6'h0);
		frame(1, 9'h0, 6'h0);
		frame(0, 9'h0, 6'h0);
		repeat (2) frame(1, 9'h0, 6'h0);
		// One idle cycle lets the second bad frame end before looking
		v110_line_model_inst.go_idle(1);
		chk_word({31'h0, inSync}, 32'h1);
		frame(1, 9'h0, 6'h0);
		v110_line_model_inst.go_idle(1);
		chk_word({31'h0, inSync}, 32'h0);
		v110_line_model_inst.go_idle(2);
		chk_count(nError, 1);
		n = words.size();
		frame(1, 9'h0, 6'h0);
		v110_line_model_inst.go_idle(3);
		chk_count(words.size(), n);
		frame(0, 9'h0, 6'h0);
		v110_line_model_inst.go_idle(3);
		chk_word({31'h0, inSync}, 32'h1);
		fastAbort = 1'b1;
		step();
		fastAbort = 1'b0;
		holdMarker = 1'b1;
		step();
		holdMarker = 1'b0;
		c.rxIrqMask = 1'b1;
		cfg = c;
		step();
		fastAbort = 1'b1;
		step();
		fastAbort = 1'b0;
		repeat (2) step();
		chk_count(nError, 3);
		$display("test sync done");
	endtask

	// Several status bits change in one frame: one report, then mask and overrun
	task automatic test_change();
		channel_cfg_t c;
		int n;
		c = '0;
		c.ratePatternSelect = RATE_FULL;
		restart(c);
		frame(0, 9'h0, 6'h0);
		frame(0, 9'h0, 6'h0);
		frame(0, 9'h1D0, 6'h2A);
		v110_line_model_inst.go_idle(3);
		chk_count(nChange, 1);
		chk_word({22'h0, changeReport}, 32'h357);
		c.alterationIrqMask = 1'b1;
		cfg = c;
		frame(0, 9'h0, 6'h0);
		v110_line_model_inst.go_idle(3);
		chk_count(nChange, 1);
		c.alterationIrqMask = 1'b0;
		cfg = c;
		bufferReady = 1'b0;
		n = words.size();
		frame(0, 9'h1D0, 6'h2A);
		v110_line_model_inst.go_idle(3);
		bufferReady = 1'b1;
		chk_count(nChange, 1);
		chk_count(nOverrun, 1);
		chk_count(nError, 2);
		chk_count(words.size(), n);
		$display("test change done");
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		rst = 1'b1;
		cfg = '0;
		bufferReady = 1'b1;
		fastAbort = 1'b0;
		holdMarker = 1'b0;
		repeat (3) step();
		rst = 1'b0;
		test_rate(RATE_600, 8);
		test_rate(RATE_1200, 4);
		test_rate(RATE_2400, 2);
		test_rate(RATE_FULL, 1);
		test_sync();
		test_change();
		final_report();
	end

	// Hang guard, counted as a mismatch
	initial
	begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule // tb_v110_receive_deframer

`default_nettype wire

// File: verification/v110_line_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Serial time-slot source, one bit per clock
module v110_line_model (
	// Clock
	input wire logic sys_clk,
	// Bit stream towards the deframer
	output var logic lineValid,
	output var logic lineBit
);
	// Quiet line at time zero
	initial
	begin
		lineValid = 1'b0;
		lineBit = 1'b0;
	end

	// One bit just after the rising edge, optionally inverted
	task automatic send_bit(input logic b, input logic flip);
		@(posedge sys_clk);
		#1;
		lineValid = 1'b1;
		lineBit = b ^ flip;
	endtask

	// Released line keeps toggling so a stale bit is never mistaken for data
	task automatic go_idle(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			lineValid = 1'b0;
			lineBit = ~lineBit;
		end
	endtask

	// Ten octets; bad puts a one into the zero octet
	task automatic send_frame(input logic [47:0] d, input logic [8:0] st,
		input logic [5:0] e, input logic bad, input logic flip);
		int p;
		p = 0;
		// Far end runs this mode from its first marked descriptor on
		for (int i = 0; i < 8; i++)
			send_bit(bad && (i == 3), flip);
		for (int o = 2; o <= 10; o++)
		begin
			send_bit(1'b1, flip);
			for (int b = 2; b <= 7; b++)
			begin
				// E bits live in octet 6, data elsewhere
				if (o == 6)
					send_bit(e[b - 2], flip);
				else
				begin
					send_bit(d[p], flip);
					p++;
				end
			end
			send_bit(st[o - 2], flip);
		end
	endtask
endmodule // v110_line_model

`default_nettype wire
